// ===== logic/rom_opt_pkg.sv
/*
  Constants shared by the program-memory window device and its driver.
  Assumes an 8-bit data space, a 12-bit program space and a 125 MHz clock.
*/
package rom_opt_pkg;
  // ----------------------------------------------------------------
  // Data space and window
  // ----------------------------------------------------------------
  localparam logic [7:0]  BLK_SEL_ADDR  = 8'hC9;
  localparam logic [7:0]  WIN_FIRST     = 8'h40;
  localparam logic [7:0]  WIN_LAST      = 8'h7F;
  localparam logic [15:0] OPT_BLANK     = 16'h0000;
  // ----------------------------------------------------------------
  // Option bit positions
  // ----------------------------------------------------------------
  localparam int          OPT_EXT_STOP  = 9;
  localparam int          OPT_UVD       = 8;
  localparam int          OPT_PROTECT   = 7;
  localparam int          OPT_CLK_SRC   = 6;
  localparam int          OPT_NMI_PULL  = 3;
  localparam int          OPT_CNT_PULL  = 2;
  localparam int          OPT_WDG_HW    = 1;
  localparam int          OPT_GUARD     = 0;
  localparam logic [15:0] OPT_RSV_CLR   = 16'hFC20;
  localparam logic [15:0] OPT_RSV_SET   = 16'h0010;
  // ----------------------------------------------------------------
  // Driver register map (AXI4-Lite byte offsets)
  // ----------------------------------------------------------------
  localparam logic [4:0]  REG_CTRL      = 5'h00;
  localparam logic [4:0]  REG_CORE_CMD  = 5'h04;
  localparam logic [4:0]  REG_OPT_CMD   = 5'h08;
  localparam logic [4:0]  REG_PM_CMD    = 5'h0C;
  localparam logic [4:0]  REG_STATUS    = 5'h10;
  localparam int          CMD_WE_BIT    = 16;
  localparam int          CMD_RD_BIT    = 18;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_CORE = 2'h1,
    ST_OPT  = 2'h3,
    ST_PM   = 2'h2
  } drv_state_e;

  // True for a data-space address inside the read window
  function automatic logic in_window(input logic [7:0] a);
    in_window = (a >= WIN_FIRST) && (a <= WIN_LAST);
  endfunction
endpackage

// ===== logic/rom_if.sv
/*
  Link between the window/option device and its driving party.
  Assumes both ends share clock and the synchronous reset.
*/
`timescale 1ns/1ns
interface rom_if;
  logic        core_req;   // Data-space access, one-cycle pulse
  logic        core_we;    // Write when high
  logic [7:0]  core_addr;  // Data-space address
  logic [7:0]  core_wdata; // Write data
  logic        core_done;  // Answer pulse
  logic [7:0]  core_rdata; // Read data
  logic        prog_mode;  // Programming mode level
  logic        opt_req;    // Option access pulse
  logic        opt_we;     // Program when high
  logic [1:0]  opt_sel;    // Byte select, bit1 msb
  logic [15:0] opt_wdata;  // Option value
  logic        opt_done;   // Option answer pulse
  logic        opt_err;    // Refused, with opt_done
  logic [15:0] opt_rdata;  // Option readback
  logic        pm_req;     // Program memory read pulse
  logic [11:0] pm_addr;    // Program memory address
  logic        pm_done;    // Answer pulse
  logic [7:0]  pm_rdata;   // Read data, zero if protected

  modport dev (input core_req, core_we, core_addr, core_wdata, prog_mode, opt_req,
               opt_we, opt_sel, opt_wdata, pm_req, pm_addr,
               output core_done, core_rdata, opt_done, opt_err, opt_rdata, pm_done,
               pm_rdata);
  modport host (output core_req, core_we, core_addr, core_wdata, prog_mode, opt_req,
                opt_we, opt_sel, opt_wdata, pm_req, pm_addr,
                input core_done, core_rdata, opt_done, opt_err, opt_rdata, pm_done,
                pm_rdata);
endinterface

// ===== logic/rom_window_options.sv
/*
  Device end: data-space window onto program memory, write-only block
  selector, one-time option bytes and their decoded controls.
  Assumes program memory is outside, answering rom_data combinationally
  from rom_addr, and that rst_b at power-up stands for a blank part.
*/
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
module rom_window_options
  import rom_opt_pkg::*;
#(
  parameter bit          MASK_PART    = 1'b0,  // Factory-coded part
  parameter logic [15:0] MASK_OPTIONS = 16'h0010 // Hardwired options
) (
  input  wire logic        clock,          // Core clock
  input  wire logic        rst_b,          // Synchronous reset, low
  rom_if.dev               link,           // Core and programmer side
  output logic [11:0]      rom_addr,       // Program memory address
  input  wire logic [7:0]  rom_data,       // Program memory byte
  input  wire logic        nmi_pin,        // Interrupt pin, asynchronous
  input  wire logic        watchdog_active,// Watchdog running
  output logic             stop_allowed,   // Stop may be entered
  output logic             undervoltage_detect_option, // Detector on
  output logic             readout_block,  // External reads blocked
  output logic             clock_source_option, // 1: RC network
  output logic             nmi_pin_pullup, // Interrupt pin pull-up
  output logic             counter_pin_pullup, // Timer pin pull-up
  output logic             watchdog_hw_select, // Watchdog always on
  output logic             clock_guard_enable  // Oscillator guard
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0]  blk_r, blk_nxt;
  logic        core_done_r, core_done_nxt;
  logic [7:0]  core_rdata_r, core_rdata_nxt;
  logic [15:0] opt_r, opt_nxt;
  logic [1:0]  burnt_r, burnt_nxt;
  logic        opt_done_r, opt_done_nxt;
  logic        opt_err_r, opt_err_nxt;
  logic [15:0] opt_rd_r, opt_rd_nxt;
  logic        pm_done_r, pm_done_nxt;
  logic [7:0]  pm_rdata_r, pm_rdata_nxt;
  logic        nmi_meta_r, nmi_sync_r;
  logic        stop_ok_r, stop_ok_nxt;
  logic [15:0] opt_eff;

  // Effective options: mask parts ignore the fuse store entirely
  // hardwired mask options
  assign opt_eff = MASK_PART ? MASK_OPTIONS : opt_r;

  // ----------------------------------------------------------------
  // Program memory address
  // ----------------------------------------------------------------
  // The programmer owns the memory port during a pm_req in programming mode;
  // the core is held then, so the two never compete.
  always_comb begin
    if (link.prog_mode && link.pm_req) begin
      rom_addr = link.pm_addr;
    end else begin
      rom_addr = {blk_r, link.core_addr[5:0]};
    end
  end

  // ----------------------------------------------------------------
  // Core data-space access
  // ----------------------------------------------------------------
  // Next values for the selector and the core answer
  always_comb begin
    blk_nxt        = blk_r;
    core_done_nxt  = link.core_req;
    core_rdata_nxt = core_rdata_r;
    if (link.core_req) begin
      core_rdata_nxt = 8'h00;
      if (link.core_we && link.core_addr == BLK_SEL_ADDR) begin
        // load block number
        // Bits 7:6 are reserved and not stored
        blk_nxt = link.core_wdata[5:0];
      end
      if (!link.core_we && in_window(link.core_addr)) begin
        core_rdata_nxt = rom_data;
      end
      // Selector readback is meaningless; zero is returned
    end
  end

  // selector has no reset
  // Software must load it before the first window read.
  always_ff @(posedge clock) begin
    blk_r <= blk_nxt;
  end

  // Core answer register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      core_done_r  <= 1'b0;
      core_rdata_r <= 8'h00;
    end else begin
      core_done_r  <= core_done_nxt;
      core_rdata_r <= core_rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Option bytes and programmer reads
  // ----------------------------------------------------------------
  // Each byte has a burnt flag; a second program of it is refused so a
  // chosen configuration can never be altered.
  always_comb begin
    opt_nxt      = opt_r;
    burnt_nxt    = burnt_r;
    opt_done_nxt = 1'b0;
    opt_err_nxt  = 1'b0;
    opt_rd_nxt   = opt_rd_r;
    pm_done_nxt  = 1'b0;
    pm_rdata_nxt = pm_rdata_r;
    if (link.opt_req) begin
      opt_done_nxt = 1'b1;
      if (!link.prog_mode || MASK_PART) begin
        opt_err_nxt = 1'b1;
        opt_rd_nxt  = 16'h0000;
      end else if (link.opt_we) begin
        if ((link.opt_sel & burnt_r) != 2'b00) begin
          opt_err_nxt = 1'b1;
        end else begin
          if (link.opt_sel[0]) begin
            opt_nxt[7:0] = link.opt_wdata[7:0];
          end
          if (link.opt_sel[1]) begin
            opt_nxt[15:8] = link.opt_wdata[15:8];
          end
          burnt_nxt = burnt_r | link.opt_sel;
        end
      end else begin
        opt_rd_nxt = opt_r;
      end
    end
    if (link.pm_req) begin
      pm_done_nxt  = 1'b1;
      pm_rdata_nxt = 8'h00;
      if (link.prog_mode && !opt_eff[OPT_PROTECT]) begin
        pm_rdata_nxt = rom_data;
      end
    end
  end

  // blank store reads zero
  // Reset here models the blank state a new part is shipped in.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      opt_r      <= OPT_BLANK;
      burnt_r    <= 2'b00;
      opt_done_r <= 1'b0;
      opt_err_r  <= 1'b0;
      opt_rd_r   <= 16'h0000;
      pm_done_r  <= 1'b0;
      pm_rdata_r <= 8'h00;
    end else begin
      opt_r      <= opt_nxt;
      burnt_r    <= burnt_nxt;
      opt_done_r <= opt_done_nxt;
      opt_err_r  <= opt_err_nxt;
      opt_rd_r   <= opt_rd_nxt;
      pm_done_r  <= pm_done_nxt;
      pm_rdata_r <= pm_rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Stop gating
  // ----------------------------------------------------------------
  // The pin is asynchronous; only the second stage is ever looked at.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      nmi_meta_r <= 1'b0;
      nmi_sync_r <= 1'b0;
    end else begin
      nmi_meta_r <= nmi_pin;
      nmi_sync_r <= nmi_meta_r;
    end
  end

  always_comb begin
    stop_ok_nxt = !watchdog_active ||
                  (opt_eff[OPT_EXT_STOP] && nmi_sync_r);
  end

  // Stop permission register
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stop_ok_r <= 1'b0;
    end else begin
      stop_ok_r <= stop_ok_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Decoded options come straight from opt_eff: the option flip-flops, or MASK_OPTIONS on a mask part
  assign stop_allowed = stop_ok_r;
  assign undervoltage_detect_option = opt_eff[OPT_UVD];
  assign readout_block = opt_eff[OPT_PROTECT];
  assign clock_source_option = opt_eff[OPT_CLK_SRC];
  assign nmi_pin_pullup = opt_eff[OPT_NMI_PULL];
  assign counter_pin_pullup = opt_eff[OPT_CNT_PULL];
  assign watchdog_hw_select = opt_eff[OPT_WDG_HW];
  assign clock_guard_enable = opt_eff[OPT_GUARD];

  // Link answers
  assign link.core_done  = core_done_r;
  assign link.core_rdata = core_rdata_r;
  assign link.opt_done   = opt_done_r;
  assign link.opt_err    = opt_err_r;
  assign link.opt_rdata  = opt_rd_r;
  assign link.pm_done    = pm_done_r;
  assign link.pm_rdata   = pm_rdata_r;
endmodule

// ===== logic/rom_driver.sv
/*
  Driving end: takes commands over AXI4-Lite and plays the core or the
  programmer towards the window/option device.
  Assumes one AXI4-Lite master; wstrb and prot are not used.
*/
`timescale 1ns/1ns
module rom_driver
  import rom_opt_pkg::*;
(
  input  wire logic        clock,         // Core clock
  input  wire logic        rst_b,         // Synchronous reset, low
  input  wire logic [4:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes, ignored
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [4:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  rom_if.host              link           // Device side
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  drv_state_e  st_r, st_nxt;
  logic        pmode_r, pmode_nxt;
  logic        creq_r, creq_nxt, cwe_r, cwe_nxt;
  logic [7:0]  caddr_r, caddr_nxt, cwdata_r, cwdata_nxt;
  logic        oreq_r, oreq_nxt, owe_r, owe_nxt;
  logic [1:0]  osel_r, osel_nxt;
  logic [15:0] owdata_r, owdata_nxt;
  logic        preq_r, preq_nxt;
  logic [11:0] paddr_r, paddr_nxt;
  logic [5:0]  shadow_r, shadow_nxt;
  logic        err_r, err_nxt;
  logic [7:0]  rd_r, rd_nxt;
  logic [15:0] ord_r, ord_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        wr_go, busy;

  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign busy  = (st_r != ST_IDLE);

  // ----------------------------------------------------------------
  // Next state: bus slave, commands and link sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r; pmode_nxt = pmode_r;
    creq_nxt = 1'b0; cwe_nxt = cwe_r; caddr_nxt = caddr_r; cwdata_nxt = cwdata_r;
    oreq_nxt = 1'b0; owe_nxt = owe_r; osel_nxt = osel_r; owdata_nxt = owdata_r;
    preq_nxt = 1'b0; paddr_nxt = paddr_r;
    shadow_nxt = shadow_r; err_nxt = err_r; rd_nxt = rd_r; ord_nxt = ord_r;
    bvalid_nxt = bvalid_r && !s_axi_bready; bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r && !s_axi_rready; rresp_nxt = rresp_r; rdata_nxt = rdata_r;
    // Link answers return the sequencer to idle
    unique case (st_r)
      ST_IDLE: ;
      ST_CORE: if (link.core_done) begin
        rd_nxt = link.core_rdata;
        st_nxt = ST_IDLE;
      end
      ST_OPT: if (link.opt_done) begin
        ord_nxt = link.opt_rdata;
        err_nxt = link.opt_err;
        st_nxt  = ST_IDLE;
      end
      ST_PM: if (link.pm_done) begin
        rd_nxt = link.pm_rdata;
        st_nxt = ST_IDLE;
      end
    endcase
    // Writes: commands refused with SLVERR while a transfer is under way
    if (wr_go) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      if (s_axi_awaddr == REG_CTRL) begin
        pmode_nxt = s_axi_wdata[0];
      end else if (busy || s_axi_awaddr > REG_PM_CMD || s_axi_awaddr[1:0] != 2'b00) begin
        bresp_nxt = RESP_SLVERR;
      end else if (s_axi_awaddr == REG_CORE_CMD) begin
        if (!s_axi_wdata[CMD_WE_BIT] && s_axi_wdata[7:0] == BLK_SEL_ADDR) begin
          err_nxt = 1'b1;
        end else begin
          err_nxt    = 1'b0;
          creq_nxt   = 1'b1;
          cwe_nxt    = s_axi_wdata[CMD_WE_BIT];
          caddr_nxt  = s_axi_wdata[7:0];
          cwdata_nxt = s_axi_wdata[15:8];
          st_nxt     = ST_CORE;
          if (cwe_nxt && caddr_nxt == BLK_SEL_ADDR) begin
            shadow_nxt = s_axi_wdata[13:8];
          end
        end
      end else if (s_axi_awaddr == REG_OPT_CMD) begin
        oreq_nxt = 1'b1;
        owe_nxt  = !s_axi_wdata[CMD_RD_BIT];
        osel_nxt = s_axi_wdata[CMD_WE_BIT +: 2];
        owdata_nxt = (s_axi_wdata[15:0] & ~OPT_RSV_CLR) | OPT_RSV_SET;
        st_nxt = ST_OPT;
      end else begin
        preq_nxt  = 1'b1;
        paddr_nxt = s_axi_wdata[11:0];
        st_nxt    = ST_PM;
      end
    end
    // Reads answer from registers only, never from the link
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (s_axi_araddr == REG_CTRL) begin
        rdata_nxt[0] = pmode_r;
      end else if (s_axi_araddr == REG_STATUS) begin
        rdata_nxt = {ord_r, rd_r, shadow_r, err_r, busy};
      end else if (s_axi_araddr[1:0] != 2'b00 || s_axi_araddr > REG_STATUS) begin
        rresp_nxt = RESP_SLVERR;
      end
    end
  end

  // Register everything; the shadow copy survives only as software state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_r <= ST_IDLE; pmode_r <= 1'b0;
      creq_r <= 1'b0; cwe_r <= 1'b0; caddr_r <= 8'h00; cwdata_r <= 8'h00;
      oreq_r <= 1'b0; owe_r <= 1'b0; osel_r <= 2'h0; owdata_r <= 16'h0000;
      preq_r <= 1'b0; paddr_r <= 12'h000;
      shadow_r <= 6'h00; err_r <= 1'b0; rd_r <= 8'h00; ord_r <= 16'h0000;
      bvalid_r <= 1'b0; bresp_r <= 2'h0; rvalid_r <= 1'b0; rresp_r <= 2'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt; pmode_r <= pmode_nxt;
      creq_r <= creq_nxt; cwe_r <= cwe_nxt; caddr_r <= caddr_nxt; cwdata_r <= cwdata_nxt;
      oreq_r <= oreq_nxt; owe_r <= owe_nxt; osel_r <= osel_nxt; owdata_r <= owdata_nxt;
      preq_r <= preq_nxt; paddr_r <= paddr_nxt;
      shadow_r <= shadow_nxt; err_r <= err_nxt; rd_r <= rd_nxt; ord_r <= ord_nxt;
      bvalid_r <= bvalid_nxt; bresp_r <= bresp_nxt; rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt; rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
  assign link.prog_mode  = pmode_r;
  assign link.core_req   = creq_r;
  assign link.core_we    = cwe_r;
  assign link.core_addr  = caddr_r;
  assign link.core_wdata = cwdata_r;
  assign link.opt_req    = oreq_r;
  assign link.opt_we     = owe_r;
  assign link.opt_sel    = osel_r;
  assign link.opt_wdata  = owdata_r;
  assign link.pm_req     = preq_r;
  assign link.pm_addr    = paddr_r;
endmodule

// ===== tb/rom_link_monitor.sv
/* Concurrent checks on the link between driver and device.
   Assumes each input is tied to the link signal of that name. */
`timescale 1ns/1ns
module rom_link_monitor (
  input wire logic       clock,      // Core clock
  input wire logic       rst_b,      // Sync reset, low
  input wire logic       core_req,   // Data access pulse
  input wire logic       core_we,    // Write flag
  input wire logic [7:0] core_addr,  // Data address
  input wire logic       core_done,  // Answer pulse
  input wire logic [7:0] core_rdata, // Read data
  input wire logic       prog_mode,  // Programming mode
  input wire logic       opt_req,    // Option pulse
  input wire logic       opt_done,   // Option answer
  input wire logic       opt_err,    // Option refusal
  input wire logic       pm_req,     // Program read pulse
  input wire logic       pm_done,    // Program answer
  input wire logic [7:0] pm_rdata    // Program byte
);
  // ----------------------------------------------------------------
  // Link timing and contents
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // Reads outside the window, selector too, give zero
  property outside_zero;
    core_req && !core_we && (core_addr < 8'h40 || core_addr > 8'h7F) |=> core_rdata == 8'h00;
  endproperty
  core_answer_a: assert property (core_req |=> core_done)
    else $error("core answer missing");
  core_lone_a: assert property (core_done |-> $past(core_req))
    else $error("core answer without request");
  outside_zero_a: assert property (outside_zero)
    else $error("outside read not zero");
  opt_closed_a: assert property (opt_req && !prog_mode |=> opt_done && opt_err)
    else $error("option access outside programming mode");
  opt_answer_a: assert property (opt_req |=> opt_done)
    else $error("option answer missing");
  opt_lone_a: assert property (opt_done |-> $past(opt_req))
    else $error("option answer without request");
  pm_closed_a: assert property (pm_req && !prog_mode |=> pm_done && pm_rdata == 8'h00)
    else $error("program read outside programming mode");
  pm_answer_a: assert property (pm_req |=> pm_done)
    else $error("program answer missing");
  // Main scenarios reached
  cover property (core_req && !core_we && core_addr == 8'h40);
  cover property (opt_done && opt_err && prog_mode);
  cover property (pm_done && prog_mode);
endmodule

// ===== tb/rom_window_options_tb.sv
/* Bench: AXI4-Lite commands through the driver reach the device over the link.
   Assumes package and interface compile first; program memory is modelled here. */
`timescale 1ns/1ns
module rom_window_options_tb
  import rom_opt_pkg::*;
;
  logic clock, rst_b, nmi_pin, watchdog_active, stop_allowed;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [1:0] bresp, rresp, rsp;
  logic [11:0] rom_addr;
  logic [7:0] rom_data, a;
  logic [6:0] opts, x, mopts;
  logic [5:0] blk, off;
  logic [3:0] hs;
  int mismatches, checks_done;
  rom_if link();
  rom_driver i_rom_driver (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link));
  rom_window_options i_rom_window_options (.clock(clock), .rst_b(rst_b), .link(link),
    .rom_addr(rom_addr), .rom_data(rom_data), .nmi_pin(nmi_pin),
    .watchdog_active(watchdog_active), .stop_allowed(stop_allowed),
    .undervoltage_detect_option(opts[6]), .readout_block(opts[5]),
    .clock_source_option(opts[4]), .nmi_pin_pullup(opts[3]),
    .counter_pin_pullup(opts[2]), .watchdog_hw_select(opts[1]),
    .clock_guard_enable(opts[0]));
  rom_link_monitor i_rom_link_monitor (.clock(clock), .rst_b(rst_b),
    .core_req(link.core_req), .core_we(link.core_we), .core_addr(link.core_addr),
    .core_done(link.core_done), .core_rdata(link.core_rdata),
    .prog_mode(link.prog_mode), .opt_req(link.opt_req), .opt_done(link.opt_done),
    .opt_err(link.opt_err), .pm_req(link.pm_req), .pm_done(link.pm_done),
    .pm_rdata(link.pm_rdata));
  // Mask twin: sees the option traffic, must hide and hardwire
  rom_if mlink();
  assign {mlink.core_req, mlink.core_we, mlink.core_addr, mlink.core_wdata, mlink.pm_req,
          mlink.pm_addr} = '0;
  assign {mlink.prog_mode, mlink.opt_req, mlink.opt_we, mlink.opt_sel, mlink.opt_wdata} =
         {link.prog_mode, link.opt_req, link.opt_we, link.opt_sel, link.opt_wdata};
  rom_window_options #(.MASK_PART(1'b1), .MASK_OPTIONS(16'h0155)) i_rom_window_options_m (
    .clock(clock), .rst_b(rst_b), .link(mlink), .rom_addr(), .rom_data(8'h00), .nmi_pin(1'b0),
    .watchdog_active(1'b0), .stop_allowed(), .undervoltage_detect_option(mopts[6]),
    .readout_block(mopts[5]), .clock_source_option(mopts[4]), .nmi_pin_pullup(mopts[3]),
    .counter_pin_pullup(mopts[2]), .watchdog_hw_select(mopts[1]), .clock_guard_enable(mopts[0]));
  // ----------------------------------------------------------------
  // Memory model and bus tasks
  // ----------------------------------------------------------------
  // Block bits mixed in make a wrong block visible
  function automatic logic [7:0] mem(input logic [11:0] ad);
    return ad[7:0] ^ {ad[11:6], 2'b01};
  endfunction
  assign rom_data = mem(rom_addr);
  assign hs = {rvalid, arready, bvalid, awready};
  always #4 clock = ~clock;
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Sampled at the falling edge; the next rising edge takes it
  task automatic wait_hi(input int k);
    for (int n = 0; n < 64; n++) begin
      @(negedge clock);
      if (hs[k] === 1'b1) return;
    end
    mismatches++;
    conclude();
  endtask
  task automatic axi_wr(input logic [4:0] ad, input logic [31:0] d);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    wait_hi(0);
    @(posedge clock);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    wait_hi(1);
    rsp = bresp;
    @(posedge clock);
  endtask
  task automatic axi_rd(input logic [4:0] ad, output logic [31:0] d);
    araddr <= ad;
    arvalid <= 1'b1;
    wait_hi(2);
    @(posedge clock);
    arvalid <= 1'b0;
    wait_hi(3);
    d = rdata;
    @(posedge clock);
  endtask
  // Command, then poll until the link is idle
  task automatic cmd(input logic [4:0] r, input logic [31:0] d);
    axi_wr(r, d);
    for (int n = 0; n < 16; n++) begin
      axi_rd(REG_STATUS, st);
      if (st[0] === 1'b0) return;
    end
    mismatches++;
    conclude();
  endtask
  task automatic chk_opts(input logic [15:0] e);
    x = {e[OPT_UVD], e[OPT_PROTECT], e[OPT_CLK_SRC], e[OPT_NMI_PULL], e[OPT_CNT_PULL],
         e[OPT_WDG_HW], e[OPT_GUARD]};
    check("decoded", 32'(opts), 32'(x));
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clock, rst_b, nmi_pin, watchdog_active, awvalid, wvalid, arvalid} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = '0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    // Junk in bits 7:6; offsets hit both window ends
    for (int i = 0; i < 4; i++) begin
      blk = 6'(i * 21);
      off = 6'(63 - i * 21);
      cmd(REG_CORE_CMD, {16'h0001, 2'b11, blk, BLK_SEL_ADDR});
      check("selector", 32'(st[7:2]), 32'(blk));
      cmd(REG_CORE_CMD, {24'h0, WIN_FIRST + {2'b00, off}});
      check("window byte", 32'(st[15:8]), 32'(mem({blk, off})));
    end
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 8'h3F : (i == 1) ? 8'h80 : BLK_SEL_ADDR;
      cmd(REG_CORE_CMD, {24'h0, a});
      check("outside byte", 32'(st[15:8]), 32'h0);
      check("selector read", 32'(st[1]), 32'(i == 2));
    end
    cmd(REG_OPT_CMD, 32'h0007_0000);
    check("closed option", 32'(st[1]), 32'h1);
    cmd(REG_PM_CMD, 32'h0000_0ABC);
    check("closed program", 32'(st[15:8]), 32'h0);
    axi_wr(REG_CTRL, 32'h1);
    axi_rd(REG_CTRL, st);
    check("control", st, 32'h1);
    cmd(REG_OPT_CMD, 32'h0007_0000);
    check("blank", 32'(st[31:16]), 32'(OPT_BLANK));
    chk_opts(OPT_BLANK);
    cmd(REG_PM_CMD, 32'h0000_0ABC);
    check("program byte", 32'(st[15:8]), 32'(mem(12'hABC)));
    watchdog_active <= 1'b1;
    nmi_pin <= 1'b1;
    repeat (6) @(posedge clock);
    check("stop", 32'(stop_allowed), 32'h0);
    cmd(REG_OPT_CMD, 32'h0001_00EF);
    check("first program", 32'(st[1]), 32'h0);
    cmd(REG_OPT_CMD, 32'h0001_0000);
    check("second program", 32'(st[1]), 32'h1);
    cmd(REG_OPT_CMD, 32'h0002_FF00);
    cmd(REG_OPT_CMD, 32'h0007_0000);
    check("options", 32'(st[31:16]), 32'h03DF);
    chk_opts(16'h03DF);
    repeat (6) @(posedge clock);
    check("stop", 32'(stop_allowed), 32'h1);
    nmi_pin <= 1'b0;
    repeat (6) @(posedge clock);
    check("stop", 32'(stop_allowed), 32'h0);
    watchdog_active <= 1'b0;
    repeat (6) @(posedge clock);
    check("stop", 32'(stop_allowed), 32'h1);
    cmd(REG_PM_CMD, 32'h0000_0ABC);
    check("protected byte", 32'(st[15:8]), 32'h0);
    axi_wr(5'h14, 32'h0);
    check("unmapped", 32'(rsp), 32'(RESP_SLVERR));
    check("mask options", 32'(mopts), 32'h55);
    check("mask read", 32'(mlink.opt_rdata), 32'h0);
    conclude();
  end
endmodule
